/* File: hw/oxr_pkg.sv */
// Behaviour
// - a 1024-byte ram answers external data space moves, not internal data space
// - every byte reachable by data pointer moves or by page-plus-operand moves
// - 8-bit operand move: high address byte from page register, low from operand
// - without flash redirection, external moves read and write the ram
// - 16-bit pointer move: top 6 address bits ignored, low 10 decode the byte
// - ram repeats every 0x0400 bytes across the 64k external data space
package oxr_pkg;
    localparam int          OXR_DEPTH      = 1024;
    localparam int          OXR_AW         = 10;
    localparam int          OXR_PAGE_BITS  = 2;
    localparam logic [7:0]  OXR_PAGE_ADDR  = 8'hAA;
    localparam logic [7:0]  OXR_PAGE_RESET = 8'h00;
    localparam logic [7:0]  OXR_DATA_RESET = 8'h00;
endpackage

/* File: hw/oxr_ram.sv */
`timescale 1ns/10ps
module oxr_ram
    import oxr_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        sfr_we_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  page_select_o,
    input  wire logic        xdata_move_op_i,
    input  wire logic        xdata_we_i,
    input  wire logic        xdata_short_i,
    input  wire logic [15:0] data_pointer_reg_i,
    input  wire logic [7:0]  xdata_operand_i,
    input  wire logic [7:0]  xdata_wdata_i,
    input  wire logic        flash_redirect_i,
    output logic      [7:0]  xdata_rdata_o,
    output logic             xdata_rvalid_o
);
    logic [1:0]        rst_sync;
    logic              rstn;
    logic [7:0]        onchip_xdata_ram_page_select;
    logic [7:0]        onchip_xdata_ram [OXR_DEPTH];
    logic              page_hit;
    logic [15:0]       full_addr;
    logic [OXR_AW-1:0] page_idx;
    logic [OXR_AW-1:0] ram_idx;
    logic              ram_sel;
    logic              ram_wr;
    logic              ram_rd;

    // internal reset leaves on a clock edge, never between two
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'h1};
        end
    end

    assign rstn = rst_sync[1];

    assign page_hit = sfr_we_i && (sfr_addr_i == OXR_PAGE_ADDR);

    always_ff @(posedge sys_clk_i or negedge rstn) begin
        if (!rstn) begin
            onchip_xdata_ram_page_select <= OXR_PAGE_RESET;
        end else if (page_hit) begin
            onchip_xdata_ram_page_select <= sfr_wdata_i;
        end
    end

    assign page_select_o = onchip_xdata_ram_page_select;

    assign full_addr = xdata_short_i ? {onchip_xdata_ram_page_select, xdata_operand_i}
                                     : data_pointer_reg_i;
    // upper page bits stay readable but cannot reach beyond the four pages
    assign page_idx = {onchip_xdata_ram_page_select[OXR_PAGE_BITS-1:0], xdata_operand_i};
    // dropped top pointer bits repeat the ram, so linear fills need no pointer reset
    assign ram_idx = xdata_short_i ? page_idx
                                   : full_addr[OXR_AW-1:0];

    // flash redirection owns the move when active
    assign ram_sel = xdata_move_op_i && !flash_redirect_i;
    assign ram_wr  = ram_sel && xdata_we_i;
    assign ram_rd  = ram_sel && !xdata_we_i;

    // no reset on storage: contents are undefined after power-up
    always_ff @(posedge sys_clk_i) begin
        if (ram_wr) begin
            onchip_xdata_ram[ram_idx] <= xdata_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn) begin
        if (!rstn) begin
            xdata_rvalid_o <= 1'h0;
        end else begin
            xdata_rvalid_o <= ram_rd;
        end
    end

    // read data holds until the next read, so a slow core may take it late
    always_ff @(posedge sys_clk_i or negedge rstn) begin
        if (!rstn) begin
            xdata_rdata_o <= OXR_DATA_RESET;
        end else if (ram_rd) begin
            xdata_rdata_o <= onchip_xdata_ram[ram_idx];
        end
    end

    a_read_valid: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        (xdata_move_op_i && !xdata_we_i && !flash_redirect_i)
        |=> xdata_rvalid_o
    )
    else $error("read not answered");

    a_write_silent: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        (xdata_move_op_i && xdata_we_i)
        |=> !xdata_rvalid_o
    )
    else $error("answer after write");

    a_redirect_block: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        (!xdata_move_op_i || flash_redirect_i)
        |=> !xdata_rvalid_o
    )
    else $error("answer without ram move");

    a_rdata_hold: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        !(xdata_move_op_i && !xdata_we_i && !flash_redirect_i)
        |=> $stable(xdata_rdata_o)
    )
    else $error("read data moved without read");

    a_alias_idx: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        !xdata_short_i
        |-> ram_idx == data_pointer_reg_i[OXR_AW-1:0]
    )
    else $error("pointer decode wrong");

    a_pointer_full: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        !xdata_short_i
        |-> full_addr == data_pointer_reg_i
    )
    else $error("pointer address not used");

    a_page_idx: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        xdata_short_i
        |-> ram_idx == {onchip_xdata_ram_page_select[OXR_PAGE_BITS-1:0], xdata_operand_i}
    )
    else $error("page decode wrong");

    a_high_byte: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        xdata_short_i
        |-> full_addr[15:8] == onchip_xdata_ram_page_select
    )
    else $error("high byte not page");

    a_low_byte: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        xdata_short_i
        |-> full_addr[7:0] == xdata_operand_i
    )
    else $error("low byte not operand");

    a_page_write: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        (sfr_we_i && sfr_addr_i == OXR_PAGE_ADDR)
        |=> page_select_o == $past(sfr_wdata_i)
    )
    else $error("page register not written");

    a_page_hold: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        !sfr_we_i
        |=> $stable(page_select_o)
    )
    else $error("page changed without write");

    a_other_address: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        (sfr_we_i && sfr_addr_i != OXR_PAGE_ADDR)
        |=> $stable(page_select_o)
    )
    else $error("page changed by other register");

    a_write_taken: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        (xdata_move_op_i && xdata_we_i && !flash_redirect_i)
        |-> ram_wr
    )
    else $error("ram write dropped");

    a_redirect_no_write: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        flash_redirect_i
        |-> !ram_wr
    )
    else $error("ram written while redirected");

    a_redirect_no_read: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        flash_redirect_i
        |-> !ram_rd
    )
    else $error("ram read while redirected");

    a_idle_no_write: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        !xdata_move_op_i
        |-> !ram_wr
    )
    else $error("ram written without move");

    a_idle_no_read: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        !xdata_move_op_i
        |-> !ram_rd
    )
    else $error("ram read without move");

    a_wrap_rw: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        (ram_wr ##1 (ram_rd && ram_idx == $past(ram_idx)))
        |=> xdata_rdata_o == $past(xdata_wdata_i, 2)
    )
    else $error("alias readback wrong");

    a_pointer_then_page: assert property (
        @(posedge sys_clk_i) disable iff (!rstn)
        ((ram_wr && !xdata_short_i) ##1 (ram_rd && xdata_short_i && ram_idx == $past(ram_idx)))
        |=> xdata_rdata_o == $past(xdata_wdata_i, 2)
    )
    else $error("pointer write not seen by page read");
endmodule

/* File: tb/onchip_xdata_ram_addressing_tb_top.sv */
`timescale 1ns/10ps
module onchip_xdata_ram_addressing_tb_top;
    logic        clk = 1'h0, rstn, swe, rv;
    logic [3:0]  ct;
    logic [7:0]  sa, sd, pg, wd, rd, q [$];
    logic [15:0] pt;
    logic [31:0] s = 32'hF362;
    int          n_errors, samples_checked;
    initial forever #10 clk = ~clk;
    oxr_core core (.clk_i(clk), .ct_o(ct), .pt_o(pt), .wd_o(wd));
    oxr_ram uut (.sys_clk_i(clk), .rstn_i(rstn), .sfr_we_i(swe), .sfr_addr_i(sa),
        .sfr_wdata_i(sd), .page_select_o(pg), .xdata_move_op_i(ct[3]), .xdata_we_i(ct[2]),
        .xdata_short_i(ct[1]), .data_pointer_reg_i(pt), .xdata_operand_i(pt[7:0]), .xdata_wdata_i(wd),
        .flash_redirect_i(ct[0]), .xdata_rdata_o(rd), .xdata_rvalid_o(rv));
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic sfr_wr(input logic [7:0] a, d);
        @(posedge clk) #2 {swe, sa, sd} = {1'h1, a, d};
        @(posedge clk) #2 swe = 1'h0;
    endtask
    task automatic chk(input logic [7:0] g, e, input string n);
        samples_checked++;
        if (g !== e) $display("wrong value %s exp %h got %h", n, e, g);
        n_errors += int'(g !== e);
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // an answer with nothing queued is itself a mismatch
    always @(posedge clk) if (rv === 1'h1) begin
        chk(8'(q.size() != 0), 8'h01, "answer queued");
        if (q.size() != 0) chk(rd, q.pop_front(), "rdata");
    end
    initial begin
        {rstn, swe, sa, sd} = '0;
        repeat (12) @(posedge clk);
        #2 rstn = 1'h1;
        repeat (3) @(posedge clk);
        #2 chk(pg, oxr_pkg::OXR_PAGE_RESET, "page reset");
        chk(rd, oxr_pkg::OXR_DATA_RESET, "rdata reset");
        repeat (40) begin
            s = xs(s);
            sfr_wr(oxr_pkg::OXR_PAGE_ADDR, s[31:24]);
            chk(pg, s[31:24], "page");
            sfr_wr({s[7:1], ~oxr_pkg::OXR_PAGE_ADDR[0]}, ~s[31:24]);
            chk(pg, s[31:24], "page kept");
            core.mv(3'h6, s[15:0], s[23:16]);
            core.mv(3'h5, {s[15:10], s[25:24], s[7:0]}, ~s[23:16]);
            core.mv(3'h1, {s[15:10], s[25:24], s[7:0]}, 8'h00);
            q.push_back(s[23:16]);
            core.mv(3'h0, {s[5:0], s[25:24], s[7:0]}, 8'h00);
            sfr_wr(oxr_pkg::OXR_PAGE_ADDR, {~s[31:26], s[25:24]});
            q.push_back(s[15:8]);
            core.mv_pair(3'h4, {s[21:16], s[25:24], s[7:0]}, s[15:8], 3'h2, {~s[15:8], s[7:0]});
        end
        for (int i = 0; i < 8 && q.size() != 0; i++) @(posedge clk);
        chk(8'(q.size()), 8'h00, "answers pending");
        @(posedge clk) #2 print_verdict();
    end
endmodule

/* File: tb/oxr_core.sv */
`timescale 1ns/10ps
module oxr_core (
    input  wire logic        clk_i,
    output logic      [3:0]  ct_o,
    output logic      [15:0] pt_o,
    output logic      [7:0]  wd_o
);
    initial {ct_o, pt_o, wd_o} = '0;
    task automatic mv(input logic [2:0] c, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i) #2 {ct_o, pt_o, wd_o} = {1'h1, c, a, d};
        @(posedge clk_i) #2 {ct_o[3], pt_o, wd_o} = {1'h0, ~a, ~d}; // lines go stale, not held
    endtask
    // write then read on the very next edge, the tightest order the core can issue
    task automatic mv_pair(input logic [2:0] cw, input logic [15:0] aw, input logic [7:0] d,
                           input logic [2:0] cr, input logic [15:0] ar);
        @(posedge clk_i) #2 {ct_o, pt_o, wd_o} = {1'h1, cw, aw, d};
        @(posedge clk_i) #2 {ct_o, pt_o, wd_o} = {1'h1, cr, ar, ~d};
        @(posedge clk_i) #2 {ct_o[3], pt_o, wd_o} = {1'h0, ~ar, d};
    endtask
endmodule
